// >>> src/gpp_pkg.sv
// Notes on behaviour
// - Pins are grouped in ports of at most sixteen, each pin with its own mode and latch bits.
// - Reset puts every pin in quasi-bidirectional mode.
// - Reset loads every bit of each port's sixteen-bit output latch with one.
// - Mode 00b turns the pin driver off so the pin is a pure input.
// - Each port's pin-level register shows the level of its pins through a two-flop synchronizer, two cycles late.
// - Mode 01b drives the pin high and low from its latch bit.
// - Mode 10b drives low for latch zero and releases the pin for latch one.
// - Mode 11b drives the pin low whenever its latch bit is zero.
// - Quasi mode with latch one drives a low pin strongly high for two cycles, then releases it.
package gpp_pkg;
   localparam int unsigned NUM_PORTS     = 5;
   localparam int unsigned PORT_PINS     = 16;
   localparam int unsigned NUM_PINS      = NUM_PORTS * PORT_PINS;
   localparam int unsigned ADDR_W        = 7;
   localparam int unsigned MODE_W        = 2;

   // Byte offsets: each port owns a 16-byte window
   localparam logic [6:0]  PORT_STRIDE   = 7'h10;
   localparam logic [3:0]  OFF_MODE      = 4'h0;
   localparam logic [3:0]  OFF_LATCH     = 4'h4;
   localparam logic [3:0]  OFF_LEVEL     = 4'h8;

   localparam logic [31:0] MODE_RESET    = 32'hFFFFFFFF;
   localparam logic [15:0] LATCH_RESET   = 16'hFFFF;

   localparam logic [1:0]  PULSE_CYCLES  = 2'h2;

   typedef enum logic [1:0] {
      GPP_MODE_INPUT = 2'h0,
      GPP_MODE_PUSH  = 2'h1,
      GPP_MODE_OPEN  = 2'h2,
      GPP_MODE_QUASI = 2'h3
   } gpp_mode_t;

   typedef enum logic [2:0] {
      GPP_Q_ARMED = 3'h1,
      GPP_Q_PULSE = 3'h2,
      GPP_Q_SPENT = 3'h4
   } gpp_qstate_t;
endpackage : gpp_pkg

// >>> src/gpp_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_drv
(
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   // Control
   input  wire logic [1:0]  i_mode,
   input  wire logic        i_latch,
   input  wire logic        i_level,
   // Pad drive
   output logic             o_pad_out,
   output logic             o_pad_oe
);
   gpp_pkg::gpp_qstate_t  qstate;
   logic [1:0]            pulse_cnt;
   logic                  quasi_hi;

   assign quasi_hi = (i_mode == gpp_pkg::GPP_MODE_QUASI) && i_latch;

   // quasi high kick
   // Re-arms only after the pin is seen high or quasi_hi drops, so a pin held low outside
   // is kicked once rather than fought forever.
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         qstate    <= gpp_pkg::GPP_Q_ARMED;
         pulse_cnt <= 2'h0;
      end
      else
      begin
         unique case (qstate)
            gpp_pkg::GPP_Q_ARMED:
            begin
               if (quasi_hi && !i_level)
               begin
                  qstate    <= gpp_pkg::GPP_Q_PULSE;
                  pulse_cnt <= gpp_pkg::PULSE_CYCLES - 2'h1;
               end
            end
            gpp_pkg::GPP_Q_PULSE:
            begin
               if (!quasi_hi)
                  qstate <= gpp_pkg::GPP_Q_ARMED;
               else if (pulse_cnt == 2'h0)
                  qstate <= gpp_pkg::GPP_Q_SPENT;
               else
                  pulse_cnt <= pulse_cnt - 2'h1;
            end
            gpp_pkg::GPP_Q_SPENT:
            begin
               if (!quasi_hi || i_level)
                  qstate <= gpp_pkg::GPP_Q_ARMED;
            end
            default:
               qstate <= gpp_pkg::GPP_Q_ARMED;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pad_out <= 1'b1;
         o_pad_oe  <= 1'b0;
      end
      else
      begin
         unique case (i_mode)
            gpp_pkg::GPP_MODE_INPUT:
            begin
               o_pad_out <= 1'b0;
               o_pad_oe  <= 1'b0;
            end
            gpp_pkg::GPP_MODE_PUSH:
            begin
               o_pad_out <= i_latch;
               o_pad_oe  <= 1'b1;
            end
            gpp_pkg::GPP_MODE_OPEN:
            begin
               o_pad_out <= 1'b0;
               o_pad_oe  <= !i_latch;
            end
            gpp_pkg::GPP_MODE_QUASI:
            begin
               o_pad_out <= i_latch;
               o_pad_oe  <= !i_latch
                            || (qstate == gpp_pkg::GPP_Q_ARMED && !i_level)
                            || (qstate == gpp_pkg::GPP_Q_PULSE && pulse_cnt != 2'h0);
            end
         endcase
      end
   end
endmodule : gpp_pin_drv
`default_nettype wire

// >>> src/gpp_port.sv
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gpp_port
(
   // Clock and reset
   input  wire logic                         i_sys_clk,
   input  wire logic                         i_resetn,
   // Avalon-MM slave
   input  wire logic [gpp_pkg::ADDR_W-1:0]   i_avs_address,
   input  wire logic                         i_avs_read,
   input  wire logic                         i_avs_write,
   input  wire logic [31:0]                  i_avs_writedata,
   input  wire logic [3:0]                   i_avs_byteenable,
   output logic      [31:0]                  o_avs_readdata,
   output logic                              o_avs_waitrequest,
   // Pads
   input  wire logic [gpp_pkg::NUM_PINS-1:0] i_pad_in,
   output logic      [gpp_pkg::NUM_PINS-1:0] o_pad_out,
   output logic      [gpp_pkg::NUM_PINS-1:0] o_pad_oe
);
   localparam int unsigned NP = gpp_pkg::NUM_PORTS;
   localparam int unsigned PP = gpp_pkg::PORT_PINS;

   logic [31:0]                  mode_reg  [NP];
   logic [PP-1:0]                latch_reg [NP];
   logic [gpp_pkg::NUM_PINS-1:0] pad_meta;
   logic [gpp_pkg::NUM_PINS-1:0] pad_level;
   logic                         ack_q;
   logic                         bus_req;
   logic [2:0]                   port_idx;
   logic [3:0]                   reg_off;
   logic                         port_hit;
   logic [31:0]                  next_readdata;

   // Merge write data into an old word by byte lane
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
            res[8*b +: 8] = new_v[8*b +: 8];
      end
      return res;
   endfunction : lane_merge

   assign port_idx = i_avs_address[6:4];
   assign reg_off  = i_avs_address[3:0];
   assign port_hit = (port_idx < 3'(NP));
   assign bus_req  = i_avs_read || i_avs_write;

   // One wait state on every access; the answer lands on the second edge
   assign o_avs_waitrequest = bus_req && !ack_q;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         ack_q <= 1'b0;
      else
         ack_q <= bus_req && !ack_q;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         pad_meta  <= '0;
         pad_level <= '0;
      end
      else
      begin
         pad_meta  <= i_pad_in;
         pad_level <= pad_meta;
      end
   end

   genvar gp;
   generate
      for (gp = 0; gp < NP; gp++)
      begin : g_port
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               mode_reg[gp]  <= gpp_pkg::MODE_RESET;
               latch_reg[gp] <= gpp_pkg::LATCH_RESET;
            end
            else if (i_avs_write && ack_q && port_idx == 3'(gp))
            begin
               if (reg_off == gpp_pkg::OFF_MODE)
                  mode_reg[gp] <= lane_merge(mode_reg[gp], i_avs_writedata,
                                             i_avs_byteenable);
               if (reg_off == gpp_pkg::OFF_LATCH)
                  latch_reg[gp] <= PP'(lane_merge({16'h0000, latch_reg[gp]},
                                                  i_avs_writedata,
                                                  i_avs_byteenable));
            end
         end
      end
   endgenerate

   genvar gi;
   generate
      for (gi = 0; gi < gpp_pkg::NUM_PINS; gi++)
      begin : g_pin
         gpp_pin_drv u_drv
         (
            .i_sys_clk (i_sys_clk),
            .i_resetn  (i_resetn),
            .i_mode    (mode_reg[gi / PP][2*(gi % PP) +: 2]),
            .i_latch   (latch_reg[gi / PP][gi % PP]),
            .i_level   (pad_level[gi]),
            .o_pad_out (o_pad_out[gi]),
            .o_pad_oe  (o_pad_oe[gi])
         );
      end
   endgenerate

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      next_readdata = 32'h00000000;
      if (port_hit)
      begin
         unique case (reg_off)
            gpp_pkg::OFF_MODE:
               next_readdata = mode_reg[port_idx];
            gpp_pkg::OFF_LATCH:
               next_readdata = {16'h0000, latch_reg[port_idx]};
            gpp_pkg::OFF_LEVEL:
               next_readdata = {16'h0000, pad_level[16*port_idx +: 16]};
            default:
               next_readdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_avs_readdata <= 32'h00000000;
      else if (i_avs_read && !ack_q)
         o_avs_readdata <= next_readdata;
   end
endmodule : gpp_port
`default_nettype wire

// >>> sim/gpp_pads.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_pads
(
   // Pad drive and external loads
   input  wire logic [79:0] i_pad_out,
   input  wire logic [79:0] i_pad_oe,
   input  wire logic [79:0] i_hold_low,
   // Resolved levels
   output logic      [79:0] o_level
);
   // released pins rise through pull-up
   // A hard external load beats any drive, so a held pin stays low
   assign o_level = ~i_hold_low & (~i_pad_oe | i_pad_out);
endmodule : gpp_pads
`default_nettype wire

// >>> sim/gpp_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_port_asserts
(
   // Clock, reset, bus
   input wire logic        i_sys_clk,
   input wire logic        i_resetn,
   input wire logic [6:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   // Pads
   input wire logic [79:0] i_pad_in,
   input wire logic [79:0] o_pad_out,
   input wire logic [79:0] o_pad_oe
);
   // Shadow of pin 0 only, to keep helper logic small
   logic [1:0] mode0;
   logic       latch0;
   logic       req;
   assign req = i_avs_read | i_avs_write;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         mode0  <= 2'h3;
         latch0 <= 1'h1;
      end
      else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0])
      begin
         if (i_avs_address == 7'h00)
            mode0 <= i_avs_writedata[1:0];
         if (i_avs_address == 7'h04)
            latch0 <= i_avs_writedata[0];
      end
   end
   sequence kick_s;
      (o_pad_oe[0] && o_pad_out[0]) [*2] ##1 !o_pad_oe[0];
   endsequence
   wait_once_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("no answer after one wait state");
   wait_short_a: assert property (req && !o_avs_waitrequest |=> !req || o_avs_waitrequest)
      else $error("answer held too long");
   reset_kick_a: assert property ($rose(i_resetn) |-> ##[1:3] (&o_pad_oe))
      else $error("no quasi kick after reset");
   input_off_a: assert property (mode0 == 2'h0 && $past(mode0) == 2'h0 |-> !o_pad_oe[0])
      else $error("input pin driven");
   push_drive_a: assert property (mode0 == 2'h1 && $past(mode0) == 2'h1
      |-> o_pad_oe[0] && o_pad_out[0] == $past(latch0)) else $error("push drive wrong");
   open_drain_a: assert property (mode0 == 2'h2 && $past(mode0) == 2'h2
      |-> o_pad_oe[0] == !$past(latch0) && !(o_pad_oe[0] && o_pad_out[0]))
      else $error("open drain drive wrong");
   quasi_low_a: assert property (mode0 == 2'h3 && $past(mode0) == 2'h3 && !$past(latch0)
      |-> o_pad_oe[0] && !o_pad_out[0]) else $error("quasi low not driven");
   quasi_kick_a: assert property (mode0 == 2'h3 && $past(mode0) == 2'h3 && latch0
      && $past(latch0) && $rose(o_pad_oe[0]) |-> kick_s) else $error("kick length wrong");
endmodule : gpp_port_asserts
bind gpp_port gpp_port_asserts i_chk (.*);
`default_nettype wire

// >>> sim/gpp_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_port_bench;
   logic        i_sys_clk;
   logic        i_resetn;
   logic [6:0]  i_avs_address;
   logic        i_avs_read;
   logic        i_avs_write;
   logic [31:0] i_avs_writedata;
   logic [3:0]  i_avs_byteenable;
   logic [31:0] o_avs_readdata;
   logic        o_avs_waitrequest;
   logic [79:0] i_pad_in;
   logic [79:0] o_pad_out;
   logic [79:0] o_pad_oe;
   logic [79:0] hold_low;
   logic [31:0] rd;
   int          err_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   gpp_port i_dut (.*);
   gpp_pads i_pads (.i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe), .i_hold_low(hold_low),
                    .o_level(i_pad_in));
   initial
   begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end
   // Ceiling well above the 190 or so cycles the run needs
   always @(posedge i_sys_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 4000)
      begin
         err_count = err_count + 1;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   // Request held until waitrequest is seen low at a rising edge; data taken there
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge i_sys_clk);
      i_avs_address    <= a;
      i_avs_writedata  <= d;
      i_avs_byteenable <= be;
      i_avs_write      <= wr;
      i_avs_read       <= !wr;
      @(posedge i_sys_clk);
      while (o_avs_waitrequest)
         @(posedge i_sys_clk);
      rd = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read  <= 1'b0;
   endtask : bus
   task automatic rdc(input logic [6:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000, 4'h0);
      check(rd, e);
   endtask : rdc
   task automatic reset_vals;
      for (int p = 0; p < 5; p++)
      begin
         rdc(7'(p * 16), 32'hFFFFFFFF);
         rdc(7'(p * 16 + 4), 32'h0000FFFF);
      end
      rdc(7'h0C, 32'h00000000);
      rdc(7'h50, 32'h00000000);
   endtask : reset_vals
   task automatic push_pull;
      bus(1'b1, 7'h10, 32'h55555555, 4'hF);
      bus(1'b1, 7'h14, 32'h0000A5C3, 4'hF);
      bus(1'b1, 7'h14, 32'h0000FF00, 4'h1);
      repeat (5) @(posedge i_sys_clk);
      check({o_pad_oe[31:16], o_pad_out[31:16]}, 32'hFFFFA500);
      check({o_pad_oe[15:0], 16'h0000}, 32'h00000000);
      rdc(7'h18, 32'h0000A500);
   endtask : push_pull
   task automatic input_mode;
      hold_low[47:32] <= 16'h0F0F;
      bus(1'b1, 7'h20, 32'h00000000, 4'hF);
      repeat (5) @(posedge i_sys_clk);
      check({o_pad_oe[47:32], 16'h0000}, 32'h00000000);
      rdc(7'h28, 32'h0000F0F0);
   endtask : input_mode
   task automatic open_drain;
      bus(1'b1, 7'h30, 32'hAAAAAAAA, 4'hF);
      bus(1'b1, 7'h34, 32'h000000FF, 4'hF);
      repeat (5) @(posedge i_sys_clk);
      check({o_pad_oe[63:48], o_pad_out[63:48] & o_pad_oe[63:48]}, 32'hFF000000);
      rdc(7'h38, 32'h000000FF);
   endtask : open_drain
   task automatic quasi_mode;
      int n;
      // Latch ones set first on the pins read as inputs
      bus(1'b1, 7'h44, 32'h00000F00, 4'hF);
      repeat (5) @(posedge i_sys_clk);
      hold_low[72] <= 1'b1;
      n = 0;
      repeat (10)
      begin
         @(negedge i_sys_clk);
         n += o_pad_oe[72];
      end
      check(32'(n), 32'h00000002);
      check({o_pad_oe[79:64], o_pad_out[79:64]}, 32'hF0FF0F00);
      rdc(7'h48, 32'h00000E00);
   endtask : quasi_mode
   // Port 0 walks every mode so the pin 0 checker sees each one
   task automatic port0_modes;
      bus(1'b1, 7'h04, 32'h0000FF00, 4'hF);
      bus(1'b1, 7'h00, 32'h00000000, 4'hF);
      repeat (5) @(posedge i_sys_clk);
      check({o_pad_oe[15:0], 16'h0000}, 32'h00000000);
      rdc(7'h08, 32'h0000FFFF);
      bus(1'b1, 7'h00, 32'h55555555, 4'hF);
      repeat (5) @(posedge i_sys_clk);
      check({o_pad_oe[15:0], o_pad_out[15:0]}, 32'hFFFFFF00);
      rdc(7'h08, 32'h0000FF00);
      bus(1'b1, 7'h00, 32'hAAAAAAAA, 4'hF);
      repeat (5) @(posedge i_sys_clk);
      check({o_pad_oe[15:0], o_pad_out[15:0] & o_pad_oe[15:0]}, 32'h00FF0000);
      bus(1'b1, 7'h00, 32'hFFFFFFFF, 4'hF);
      repeat (5) @(posedge i_sys_clk);
      check({o_pad_oe[15:0], o_pad_out[15:0]}, 32'h00FFFF00);
      rdc(7'h08, 32'h0000FF00);
   endtask : port0_modes
   // Reset in mid-run must undo every earlier setting
   task automatic mid_reset;
      @(posedge i_sys_clk);
      i_resetn <= 1'b0;
      repeat (5) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      reset_vals();
   endtask : mid_reset
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   initial
   begin
      i_resetn = 1'b0;
      i_avs_address = 7'h00;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_writedata = 32'h00000000;
      i_avs_byteenable = 4'h0;
      hold_low = 80'h0;
      repeat (5) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      reset_vals();
      push_pull();
      input_mode();
      open_drain();
      quasi_mode();
      port0_modes();
      mid_reset();
      print_verdict();
   end
endmodule : gpp_port_bench
`default_nettype wire
